// file: hw/aop_highpass.sv
// First-order digital high-pass filter for one channel, with truncating or rounding output.
// Assumes one sample strobe per conversion and samples in two's complement.
`timescale 1ns/10ps
`default_nettype none
`include "aop_params.svh"
module aop_highpass #(
    parameter int WIDTH = `AOP_ADC_BITS,
    parameter int FRAC = `AOP_HPF_FRAC_BITS
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sampleStrobe,
    input wire logic filterEnable,
    input wire logic roundEnable,
    input wire logic [3:0] coeffK,
    input wire logic signed [WIDTH-1:0] sampleIn,
    output logic signed [WIDTH-1:0] sampleOut
);
    import aop_pkg::*;
    localparam int ACC = WIDTH + FRAC + 4;
    localparam int WIDE = ACC + 16;
    localparam logic signed [ACC-1:0] MAXV = ACC'((2 ** (WIDTH - 1)) - 1);
    localparam logic signed [ACC-1:0] MINV = -ACC'(2 ** (WIDTH - 1));
    localparam logic signed [ACC-1:0] HALF = ACC'(2 ** (FRAC - 1));

    logic signed [ACC-1:0] xPrev_q, yPrev_q, xFull, sumS, yNew, rounded, scaled;
    logic signed [WIDE-1:0] num, quot;

    // The gain 2^k/(2^k+1) is an exact quotient at FRAC fraction bits; a shift series would
    // spare the divider but misses the output by several steps when k is small.
    assign num = WIDE'(sumS) <<< coeffK;
    assign quot = num / ((WIDE'(1) <<< coeffK) + WIDE'(1));
    assign xFull = ACC'(sampleIn) <<< FRAC;
    assign sumS = xFull - xPrev_q + yPrev_q;
    assign yNew = quot[ACC-1:0];
    assign rounded = roundEnable ? yNew + HALF : yNew;
    assign scaled = rounded >>> FRAC;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            xPrev_q <= '0;
            yPrev_q <= '0;
        end else if (sampleStrobe && filterEnable) begin
            xPrev_q <= xFull;
            yPrev_q <= yNew;
        end else if (sampleStrobe) begin
            // History is cleared while bypassed so that enabling starts from rest.
            xPrev_q <= '0;
            yPrev_q <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sampleOut <= '0;
        end else if (sampleStrobe && !filterEnable) begin
            sampleOut <= sampleIn;
        end else if (sampleStrobe) begin
            if (scaled > MAXV) begin
                sampleOut <= MAXV[WIDTH-1:0];
            end else if (scaled < MINV) begin
                sampleOut <= MINV[WIDTH-1:0];
            end else begin
                sampleOut <= scaled[WIDTH-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/aop_lane_pattern.sv
// Output-lane word selector: sample data, fixed test patterns, ramp or pseudo-random words.
// Assumes sampleStrobe marks each word handed to the serializer.
`timescale 1ns/10ps
`default_nettype none
`include "aop_params.svh"
module aop_lane_pattern #(
    parameter int WIDTH = `AOP_ADC_BITS,
    parameter logic [22:0] PRBS_SEED = `AOP_PRBS_SEED,
    parameter logic [WIDTH-1:0] CUSTOM_PATTERN = `AOP_CUSTOM_PATTERN
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sampleStrobe,
    input wire logic patternOverride,
    input wire logic prbsEnable,
    input wire aop_pkg::aop_pattern_e patternCode,
    input wire logic [WIDTH-1:0] sampleIn,
    output logic [WIDTH-1:0] laneWord
);
    import aop_pkg::*;
    localparam int HALFW = WIDTH / 2;

    logic [22:0] prbs_q, prbs_d;
    logic [WIDTH-1:0] ramp_q, pick;
    logic phase_q;

    // Polynomial x^23 + x^18 + 1, advanced one step per bit of the word.
    always_comb begin
        prbs_d = prbs_q;
        for (int i = 0; i < WIDTH; i++) begin
            prbs_d = {prbs_d[21:0], prbs_d[22] ^ prbs_d[17]};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prbs_q <= PRBS_SEED;
            ramp_q <= '0;
            phase_q <= 1'b0;
        end else if (sampleStrobe) begin
            prbs_q <= prbs_d;
            ramp_q <= ramp_q + 1'b1;
            phase_q <= ~phase_q;
        end
    end

    always_comb begin
        unique case (patternCode)
            AOP_PAT_NORMAL: pick = sampleIn;
            AOP_PAT_SYNC: pick = {{(WIDTH - HALFW){1'b0}}, {HALFW{1'b1}}};
            AOP_PAT_ALTERNATE: pick = {WIDTH{phase_q}};
            AOP_PAT_CUSTOM: pick = CUSTOM_PATTERN;
            AOP_PAT_ONES: pick = {WIDTH{1'b1}};
            AOP_PAT_TOGGLE: pick = {HALFW{phase_q, ~phase_q}};
            AOP_PAT_ZEROS: pick = '0;
            AOP_PAT_RAMP: pick = ramp_q;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            laneWord <= '0;
        end else if (sampleStrobe) begin
            if (!patternOverride) begin
                laneWord <= sampleIn;
            end else if (prbsEnable) begin
                laneWord <= prbs_q[WIDTH-1:0];
            end else begin
                laneWord <= pick;
            end
        end
    end
endmodule
`default_nettype wire

// file: hw/aop_params.svh
// Constants of the ADC post-processing block: offsets, field positions, resets, codes.
// Assumes inclusion by bare name from the package and from each design file.
`ifndef AOP_PARAMS_SVH
`define AOP_PARAMS_SVH

`define AOP_ADDR_BITS 8
`define AOP_DATA_BITS 16
`define AOP_ADC_BITS 14
`define AOP_LANES 4
`define AOP_REG_RESET 16'h0000

`define AOP_ADDR_GLOBAL_CTRL 8'h03
`define AOP_ADDR_PATTERN_CTRL 8'h04
`define AOP_ADDR_CH4_GAIN_OFFSET 8'h13
`define AOP_ADDR_CH4_OFFSET_COPY 8'h14
`define AOP_ADDR_LANE_HPF_CTRL 8'h15

`define AOP_GAIN_EN_BIT 12
`define AOP_OFFSET_EN_BIT 8
`define AOP_PER_LANE_SEL_BIT 8
`define AOP_GAIN_MSB 15
`define AOP_GAIN_LSB 11
`define AOP_OFFSET_MSB 9
`define AOP_OFFSET_LSB 0
`define AOP_PRBS_LANE1_BIT 15
`define AOP_LANE1_CODE_MSB 11
`define AOP_LANE1_CODE_LSB 9
`define AOP_LANE2_CODE_MSB 8
`define AOP_LANE2_CODE_LSB 6
`define AOP_ROUND_BIT 5
`define AOP_K_MSB 4
`define AOP_K_LSB 1
`define AOP_HPF_EN_BIT 0

`define AOP_GAIN_FRAC_BITS 12
`define AOP_HPF_FRAC_BITS 8
`define AOP_PRBS_SEED 23'h7FFFFF
`define AOP_CUSTOM_PATTERN 14'h0000

`define AOP_PAT_NORMAL 3'h0
`define AOP_PAT_SYNC 3'h1
`define AOP_PAT_ALTERNATE 3'h2
`define AOP_PAT_CUSTOM 3'h3
`define AOP_PAT_ONES 3'h4
`define AOP_PAT_TOGGLE 3'h5
`define AOP_PAT_ZEROS 3'h6
`define AOP_PAT_RAMP 3'h7

`endif

// file: hw/aop_pkg.sv
// Types shared by the ADC post-processing block: bus request, sample bundle, pattern codes.
// Assumes aop_params.svh is on the include path.
package aop_pkg;
`include "aop_params.svh"

    typedef enum logic [2:0] {
        AOP_PAT_NORMAL = `AOP_PAT_NORMAL,
        AOP_PAT_SYNC = `AOP_PAT_SYNC,
        AOP_PAT_ALTERNATE = `AOP_PAT_ALTERNATE,
        AOP_PAT_CUSTOM = `AOP_PAT_CUSTOM,
        AOP_PAT_ONES = `AOP_PAT_ONES,
        AOP_PAT_TOGGLE = `AOP_PAT_TOGGLE,
        AOP_PAT_ZEROS = `AOP_PAT_ZEROS,
        AOP_PAT_RAMP = `AOP_PAT_RAMP
    } aop_pattern_e;

    typedef logic signed [`AOP_ADC_BITS-1:0] aop_sample_t;

    typedef struct packed {
        logic [`AOP_ADDR_BITS-1:0] addr;
        logic [`AOP_DATA_BITS-1:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } aop_reg_req_s;

    typedef struct packed {
        logic valid;
        aop_sample_t [`AOP_LANES-1:0] ch;
    } aop_samples_s;
endpackage

// file: hw/aop_post_proc.sv
// Top of the ADC post-processing block for channels 1 to 4: registers, high-pass filters,
// channel 4 gain and offset, and per-lane pattern selection.
// Assumes a register master on the plain strobe port and one sample strobe per conversion.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "aop_params.svh"
// Contract
// - With global gain enable set, channel 4 gain comes from bits 15-11.
// - Digital gain equals the field value times 0.2 dB.
// - With global offset enable set, channel 4 offset comes from bits 9-0.
// - The ten-bit offset is added as a signed two's-complement number.
// - With per-lane select set, bits 15 to 12 enable PRBS on lanes 1 to 4.
// - With per-lane select set, bits 11-9 and 8-6 pick patterns for lanes 1, 2.
// - Rounding control clear truncates the filter output to ADC width.
// - Rounding control set rounds the filter output to nearest at ADC width.
// - Filter output is 2^k/(2^k+1) times x(n) minus x(n-1) plus y(n-1).
// - Bit 0 enables the filter on channels 1 to 4; cleared means bypass.
// - Pattern codes map to normal, sync, alternate, custom, ones, toggle, zeros, ramp.
module aop_post_proc #(
    parameter int WIDTH = `AOP_ADC_BITS,
    parameter int LANES = `AOP_LANES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire aop_pkg::aop_reg_req_s regReq,
    output logic [`AOP_DATA_BITS-1:0] rdData,
    input wire aop_pkg::aop_samples_s sampleIn,
    output aop_pkg::aop_samples_s laneOut
);
    import aop_pkg::*;

    localparam logic signed [31:0] SAT_MAX = 32'((2 ** (WIDTH - 1)) - 1);
    localparam logic signed [31:0] SAT_MIN = -32'(2 ** (WIDTH - 1));

    // Gain factor for a field value N, in steps of 0.2 dB, scaled by 2^12.
    function automatic logic [13:0] gainFactor(input logic [4:0] n);
        logic [13:0] f;
        f = 14'h1000;
        unique case (n)
            5'h00: f = 14'h1000;
            5'h01: f = 14'h105F;
            5'h02: f = 14'h10C1;
            5'h03: f = 14'h1125;
            5'h04: f = 14'h118B;
            5'h05: f = 14'h11F4;
            5'h06: f = 14'h125F;
            5'h07: f = 14'h12CC;
            5'h08: f = 14'h133D;
            5'h09: f = 14'h13AF;
            5'h0A: f = 14'h1425;
            5'h0B: f = 14'h149D;
            5'h0C: f = 14'h1518;
            5'h0D: f = 14'h1595;
            5'h0E: f = 14'h1616;
            5'h0F: f = 14'h169A;
            5'h10: f = 14'h1721;
            5'h11: f = 14'h17AA;
            5'h12: f = 14'h1838;
            5'h13: f = 14'h18C8;
            5'h14: f = 14'h195C;
            5'h15: f = 14'h19F3;
            5'h16: f = 14'h1A8E;
            5'h17: f = 14'h1B2C;
            5'h18: f = 14'h1BCE;
            5'h19: f = 14'h1C74;
            5'h1A: f = 14'h1D1D;
            5'h1B: f = 14'h1DCB;
            5'h1C: f = 14'h1E7D;
            5'h1D: f = 14'h1F33;
            5'h1E: f = 14'h1FED;
            5'h1F: f = 14'h20AB;
        endcase
        return f;
    endfunction

    // Clamps a wide intermediate to the sample width instead of letting it wrap.
    function automatic logic [WIDTH-1:0] saturate(input logic signed [31:0] v);
        logic [WIDTH-1:0] r;
        r = v[WIDTH-1:0];
        if (v > SAT_MAX) begin
            r = SAT_MAX[WIDTH-1:0];
        end else if (v < SAT_MIN) begin
            r = SAT_MIN[WIDTH-1:0];
        end
        return r;
    endfunction

    logic [`AOP_DATA_BITS-1:0] ch4GainOffset_q;
    logic [`AOP_DATA_BITS-1:0] ch4OffsetCopy_q;
    logic [`AOP_DATA_BITS-1:0] laneHpfCtrl_q;
    logic global_gain_enable_q;
    logic global_offset_enable_q;
    logic per_lane_pattern_select_q;
    logic [`AOP_DATA_BITS-1:0] rdData_d;

    logic [4:0] ch4_gain_value;
    logic [9:0] ch4_offset_value;
    logic highpass_enable_group1;
    logic highpass_rounding_enable;
    logic [3:0] highpass_coefficient_k;

    logic [WIDTH-1:0] filtered [LANES];
    logic validA_q;
    logic validB_q;
    logic laneValid_q;
    logic [WIDTH-1:0] stageB_q [LANES];
    logic signed [31:0] factorExt;
    logic signed [31:0] gained;
    logic signed [31:0] offsetExt;
    logic signed [31:0] shifted;
    logic [WIDTH-1:0] ch4Gained;
    logic [WIDTH-1:0] ch4Final;
    logic [WIDTH-1:0] laneWord [LANES];

    // Register writes: every field takes the written value, reserved bits included,
    // so that read-back shows exactly what software stored.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ch4GainOffset_q <= `AOP_REG_RESET;
            ch4OffsetCopy_q <= `AOP_REG_RESET;
            laneHpfCtrl_q <= `AOP_REG_RESET;
        end else if (regReq.wrStrobe) begin
            unique case (regReq.addr)
                `AOP_ADDR_CH4_GAIN_OFFSET: ch4GainOffset_q <= regReq.wrData;
                `AOP_ADDR_CH4_OFFSET_COPY: ch4OffsetCopy_q <= regReq.wrData;
                `AOP_ADDR_LANE_HPF_CTRL: laneHpfCtrl_q <= regReq.wrData;
                default: ;
            endcase
        end
    end

    // Global enables live in partial registers: only the bits this block uses are stored.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            global_gain_enable_q <= 1'b0;
            global_offset_enable_q <= 1'b0;
            per_lane_pattern_select_q <= 1'b0;
        end else if (regReq.wrStrobe) begin
            if (regReq.addr == `AOP_ADDR_GLOBAL_CTRL) begin
                global_gain_enable_q <= regReq.wrData[`AOP_GAIN_EN_BIT];
                global_offset_enable_q <= regReq.wrData[`AOP_OFFSET_EN_BIT];
            end
            if (regReq.addr == `AOP_ADDR_PATTERN_CTRL) begin
                per_lane_pattern_select_q <= regReq.wrData[`AOP_PER_LANE_SEL_BIT];
            end
        end
    end

    always_comb begin
        rdData_d = '0;
        unique case (regReq.addr)
            `AOP_ADDR_GLOBAL_CTRL: begin
                rdData_d[`AOP_GAIN_EN_BIT] = global_gain_enable_q;
                rdData_d[`AOP_OFFSET_EN_BIT] = global_offset_enable_q;
            end
            `AOP_ADDR_PATTERN_CTRL: rdData_d[`AOP_PER_LANE_SEL_BIT] = per_lane_pattern_select_q;
            `AOP_ADDR_CH4_GAIN_OFFSET: rdData_d = ch4GainOffset_q;
            `AOP_ADDR_CH4_OFFSET_COPY: rdData_d = ch4OffsetCopy_q;
            `AOP_ADDR_LANE_HPF_CTRL: rdData_d = laneHpfCtrl_q;
            default: rdData_d = '0;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe and are zero otherwise.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= '0;
        end else if (regReq.rdStrobe) begin
            rdData <= rdData_d;
        end else begin
            rdData <= '0;
        end
    end

    // Only the primary copy steers the datapath; the companion copy is storage that
    // software keeps equal, so a mismatch does not disturb the output.
    assign ch4_gain_value = ch4GainOffset_q[`AOP_GAIN_MSB:`AOP_GAIN_LSB];
    assign ch4_offset_value = ch4GainOffset_q[`AOP_OFFSET_MSB:`AOP_OFFSET_LSB];
    assign highpass_enable_group1 = laneHpfCtrl_q[`AOP_HPF_EN_BIT];
    assign highpass_rounding_enable = laneHpfCtrl_q[`AOP_ROUND_BIT];
    assign highpass_coefficient_k = laneHpfCtrl_q[`AOP_K_MSB:`AOP_K_LSB];

    // Stage A: one high-pass filter per channel, all sharing one control set.
    for (genvar c = 0; c < LANES; c++) begin : g_filter
        aop_highpass #(
            .WIDTH(WIDTH),
            .FRAC(`AOP_HPF_FRAC_BITS)
        ) u_highpass (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .sampleStrobe(sampleIn.valid),
            .filterEnable(highpass_enable_group1),
            .roundEnable(highpass_rounding_enable),
            .coeffK(highpass_coefficient_k),
            .sampleIn(sampleIn.ch[c]),
            .sampleOut(filtered[c])
        );
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            validA_q <= 1'b0;
            validB_q <= 1'b0;
        end else begin
            validA_q <= sampleIn.valid;
            validB_q <= validA_q;
        end
    end

    // Stage B: channel 4 gain and offset; other channels pass with equal latency.
    assign factorExt = 32'(gainFactor(ch4_gain_value));
    assign shifted = (32'(signed'(filtered[LANES-1])) * factorExt) >>> `AOP_GAIN_FRAC_BITS;
    assign gained = global_gain_enable_q ? shifted : 32'(signed'(filtered[LANES-1]));
    assign ch4Gained = saturate(gained);
    assign offsetExt = 32'(signed'(ch4_offset_value));
    assign ch4Final = global_offset_enable_q ?
        saturate(32'(signed'(ch4Gained)) + offsetExt) : ch4Gained;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < LANES; c++) begin
                stageB_q[c] <= '0;
            end
        end else if (validA_q) begin
            for (int c = 0; c < LANES - 1; c++) begin
                stageB_q[c] <= filtered[c];
            end
            stageB_q[LANES-1] <= ch4Final;
        end
    end

    // Stage C: lane pattern selection. Codes for lanes 3 and 4 sit outside this block,
    // so those lanes offer only PRBS or normal data here.
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        aop_pattern_e code;
        if (l == 0) begin : g_code1
            assign code = aop_pattern_e'(
                laneHpfCtrl_q[`AOP_LANE1_CODE_MSB:`AOP_LANE1_CODE_LSB]);
        end else if (l == 1) begin : g_code2
            assign code = aop_pattern_e'(
                laneHpfCtrl_q[`AOP_LANE2_CODE_MSB:`AOP_LANE2_CODE_LSB]);
        end else begin : g_code_other
            assign code = AOP_PAT_NORMAL;
        end
        aop_lane_pattern #(
            .WIDTH(WIDTH),
            .PRBS_SEED(`AOP_PRBS_SEED),
            .CUSTOM_PATTERN(`AOP_CUSTOM_PATTERN)
        ) u_lane (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .sampleStrobe(validB_q),
            .patternOverride(per_lane_pattern_select_q),
            .prbsEnable(laneHpfCtrl_q[`AOP_PRBS_LANE1_BIT - l]),
            .patternCode(code),
            .sampleIn(stageB_q[l]),
            .laneWord(laneWord[l])
        );
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            laneValid_q <= 1'b0;
        end else begin
            laneValid_q <= validB_q;
        end
    end

    // The lane words are already flip-flop outputs of the lane selectors.
    always_comb begin
        laneOut = '{valid: laneValid_q, ch: '0};
        for (int l = 0; l < LANES; l++) begin
            laneOut.ch[l] = laneWord[l];
        end
    end
endmodule
`default_nettype wire

// file: tb/aop_capture_model.sv
// Capture model of the serializer side: keeps the last word set handed over.
// Assumes laneOut.valid is a one-cycle strobe for each word set.
`timescale 1ns/10ps
`default_nettype none
module aop_capture_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire aop_pkg::aop_samples_s laneOut,
    output aop_pkg::aop_samples_s capture
);
    import aop_pkg::*;
    // Words are taken only on the strobe, so held words are never seen twice.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            capture <= '0;
        end else if (laneOut.valid) begin
            capture <= laneOut;
        end
    end
endmodule
`default_nettype wire

// file: tb/aop_post_proc_properties.sv
// Concurrent checks on the ports of the ADC post-processing top.
// Assumes it is bound to aop_post_proc and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module aop_post_proc_properties (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire aop_pkg::aop_reg_req_s regReq,
    input wire logic [15:0] rdData,
    input wire aop_pkg::aop_samples_s sampleIn,
    input wire aop_pkg::aop_samples_s laneOut
);
    import aop_pkg::*;
    logic [15:0] ctl_q;
    logic sel_q;
    logic [2:0] wrAge_q;
    logic quiet;
    logic mapped;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // Shadows let the checks judge lane words without seeing the body.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q <= 16'h0000;
            sel_q <= 1'b0;
        end else if (regReq.wrStrobe && regReq.addr == 8'h15) begin
            ctl_q <= regReq.wrData;
        end else if (regReq.wrStrobe && regReq.addr == 8'h04) begin
            sel_q <= regReq.wrData[8];
        end
    end
    // Words still in flight after a write may mix old and new settings, so they are skipped.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrAge_q <= 3'h0;
        end else if (regReq.wrStrobe) begin
            wrAge_q <= 3'h0;
        end else if (wrAge_q != 3'h7) begin
            wrAge_q <= wrAge_q + 3'h1;
        end
    end
    assign quiet = wrAge_q >= 3'h4;
    assign mapped = regReq.addr inside {8'h03, 8'h04, 8'h13, 8'h14, 8'h15};
    sequence s_take;
        sampleIn.valid;
    endsequence
    sequence s_emit;
        ##3 laneOut.valid;
    endsequence
    a_rd_idle_zero: assert property (!$past(regReq.rdStrobe) |-> rdData == 16'h0000)
        else $error("read data not zero outside read answer");
    a_rd_unmapped: assert property (regReq.rdStrobe && !mapped |=> rdData == 16'h0000)
        else $error("unmapped read returned data");
    a_ctl_readback: assert property (regReq.rdStrobe && regReq.addr == 8'h15 |=> rdData == ctl_q)
        else $error("lane control word read back wrong");
    a_out_latency: assert property (s_take |-> s_emit)
        else $error("lane strobe missing three cycles after sample");
    a_no_spurious: assert property (laneOut.valid |-> $past(sampleIn.valid, 3))
        else $error("lane strobe without sample");
    a_plain_pass: assert property (laneOut.valid && quiet && !sel_q && !ctl_q[0]
        |-> laneOut.ch[2:0] == $past(sampleIn.ch[2:0], 3))
        else $error("bypass words changed");
    a_ones_lane1: assert property (laneOut.valid && quiet && sel_q && ctl_q[15:9] == 7'h04
        |-> laneOut.ch[0] == 14'h3FFF)
        else $error("lane 1 ones pattern wrong");
    a_zeros_lane2: assert property (laneOut.valid && quiet && sel_q && !ctl_q[14]
        && ctl_q[8:6] == 3'h6 |-> laneOut.ch[1] == 14'h0000)
        else $error("lane 2 zeros pattern wrong");
endmodule
`default_nettype wire

// file: tb/tb_adc_output_post_processing.sv
// Self-checking bench for the ADC post-processing block with a lane capture model.
// Assumes package, design, capture model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_output_post_processing;
    import aop_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    aop_reg_req_s regReq = '0;
    aop_samples_s sampleIn = '0;
    logic [15:0] rdData;
    aop_samples_s laneOut;
    aop_samples_s cap;
    int n_fail = 0;
    int num_checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    aop_post_proc dut (.sys_clk(sys_clk), .arst_n(arst_n), .regReq(regReq),
        .rdData(rdData), .sampleIn(sampleIn), .laneOut(laneOut));
    aop_capture_model peer (.sys_clk(sys_clk), .arst_n(arst_n), .laneOut(laneOut),
        .capture(cap));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp_reg(string what, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_word(string what, aop_sample_t e, aop_sample_t g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // Exact filter gain from rest; positive samples make integer division the floor.
    function automatic int hp(int x, int k, bit rnd);
        int d;
        d = (1 << k) + 1;
        return rnd ? (2 * x * (1 << k) + d) / (2 * d) : x * (1 << k) / d;
    endfunction
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk);
        regReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
        @(posedge sys_clk);
        regReq.wrStrobe <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regReq <= '{addr: a, wrData: 16'h0000, wrStrobe: 1'b0, rdStrobe: 1'b1};
        @(posedge sys_clk);
        regReq.rdStrobe <= 1'b0;
        #1;
        d = rdData;
    endtask
    task automatic send(aop_sample_t x [4]);
        @(posedge sys_clk);
        sampleIn <= '{valid: 1'b1, ch: {x[3], x[2], x[1], x[0]}};
        @(posedge sys_clk);
        sampleIn.valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic run(aop_sample_t x [4], aop_sample_t e [4]);
        send(x);
        for (int l = 0; l < 4; l++) begin
            cmp_word("lane word", e[l], cap.ch[l]);
        end
    endtask
    task automatic t_regs();
        logic [15:0] d;
        logic [7:0] adr [5] = '{8'h03, 8'h04, 8'h13, 8'h14, 8'h15};
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], d);
            cmp_reg("reset value", 16'h0000, d);
        end
        wr(8'h13, 16'hFBFF);
        wr(8'h14, 16'h03FF);
        rd(8'h13, d);
        cmp_reg("gain offset word", 16'hFBFF, d);
        rd(8'h14, d);
        cmp_reg("offset copy", 16'h03FF, d);
        wr(8'h16, 16'hFFFF);
        rd(8'h16, d);
        cmp_reg("unmapped read", 16'h0000, d);
        $display("t_regs done");
    endtask
    task automatic t_bypass();
        wr(8'h13, 16'hFBFD);
        run('{100, -200, 8191, -8192}, '{100, -200, 8191, -8192});
        $display("t_bypass done");
    endtask
    task automatic t_gain();
        int n [3] = '{0, 5, 31};
        int g;
        logic [15:0] d;
        wr(8'h03, 16'h1000);
        for (int i = 0; i < 3; i++) begin
            wr(8'h13, 16'((n[i] << 11) | 16'h03FD));
            g = $rtoi(4096.0 * 10.0 ** (0.01 * n[i]) + 0.5);
            run('{7, 8, 9, -1000}, '{7, 8, 9, (-1000 * g) >>> 12});
        end
        wr(8'h03, 16'h0100);
        wr(8'h14, 16'h03FD);
        run('{7, 8, 9, 1000}, '{7, 8, 9, 997});
        wr(8'h03, 16'h1100);
        rd(8'h03, d);
        cmp_reg("global enables", 16'h1100, d);
        run('{7, 8, 9, 1000}, '{7, 8, 9, ((1000 * g) >>> 12) - 3});
        wr(8'h03, 16'h0000);
        $display("t_gain done");
    endtask
    task automatic t_hp();
        logic [15:0] c [3] = '{16'h0005, 16'h0025, 16'h0015};
        aop_sample_t x [4] = '{1002, 2000, 557, 4000};
        aop_sample_t e [4];
        for (int i = 0; i < 3; i++) begin
            wr(8'h15, 16'h0000);
            run(x, x);
            wr(8'h15, c[i]);
            for (int l = 0; l < 4; l++) begin
                e[l] = hp(x[l], c[i][4:1], c[i][5]);
            end
            run(x, e);
        end
        $display("t_hp done");
    endtask
    task automatic pat(int c, aop_sample_t a, aop_sample_t b, aop_sample_t x);
        aop_sample_t e;
        case (c)
            0: e = x;
            1: e = 14'h007F;
            3, 6: e = 14'h0000;
            4: e = 14'h3FFF;
            7: e = a + 14'h0001;
            default: e = ~a;
        endcase
        cmp_word("pattern word", e, b);
        if (c == 2 || c == 5) begin
            cmp_word("pattern shape", c == 2 ? {14{a[0]}} : (a[0] ? 14'h1555 : 14'h2AAA), a);
        end
    endtask
    task automatic t_pat();
        aop_sample_t x [4] = '{11, 22, 33, 44};
        aop_samples_s w;
        wr(8'h04, 16'h0100);
        for (int c = 0; c < 8; c++) begin
            wr(8'h15, 16'(c * 16'h0240));
            send(x);
            w = cap;
            send(x);
            for (int l = 0; l < 2; l++) begin
                pat(c, w.ch[l], cap.ch[l], x[l]);
            end
            cmp_word("lane 3 normal", x[2], cap.ch[2]);
        end
        $display("t_pat done");
    endtask
    task automatic t_prbs();
        aop_sample_t x [4] = '{11, 22, 33, 44};
        aop_samples_s w;
        logic [15:0] d;
        wr(8'h15, 16'hF000);
        send(x);
        w = cap;
        send(x);
        for (int l = 0; l < 4; l++) begin
            cmp_word("prbs moves", 14'h0001, 14'(w.ch[l] !== cap.ch[l]));
        end
        wr(8'h04, 16'h0000);
        run(x, x);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(8'h15, d);
        cmp_reg("value after reset", 16'h0000, d);
        $display("t_prbs done");
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_bypass();
        t_gain();
        t_hp();
        t_pat();
        t_prbs();
        stop_test();
    end
    // The whole run needs well under a thousand cycles, so this only trips on a hang.
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        $display("mismatch watchdog expected done seen hang");
        stop_test();
    end
endmodule
bind aop_post_proc aop_post_proc_properties u_props (.sys_clk(sys_clk), .arst_n(arst_n),
    .regReq(regReq), .rdData(rdData), .sampleIn(sampleIn), .laneOut(laneOut));
`default_nettype wire
